// file: logic/ccn_pkg.sv
// Constants for the configuration, interrupt and ordering register block
package ccn_pkg;

    // Register bus widths and memory address width
    localparam int          CCN_ADDR_W          = 8;
    localparam int          CCN_DATA_W          = 8;
    localparam int          CCN_MADDR_W         = 32;

    // Register indexes
    localparam logic [7:0]  CCN_IDX_PERF_CTRL   = 8'h20;
    localparam logic [7:0]  CCN_IDX_CFG_THREE   = 8'h21;
    localparam logic [7:0]  CCN_IDX_NMI_EXT     = 8'h22;

    // Field positions, performance control
    localparam int          CCN_LOAD_STORE_SERIALIZE_BIT       = 7;

    // Field positions, config control three
    localparam int          CCN_RSER_HIGH_BIT   = 7;
    localparam int          CCN_RSER_MID_BIT    = 6;
    localparam int          CCN_RSER_LOW_BIT    = 5;

    // Field positions, interrupt and extended instruction control
    localparam int          CCN_NMI_GEN_BIT     = 2;
    localparam int          CCN_RESERVED_BIT_BIT        = 1;
    localparam int          CCN_EXT_EN_BIT      = 0;

    // Writable masks; all other bits read as zero
    localparam logic [7:0]  CCN_PERF_MASK       = 8'h80;
    localparam logic [7:0]  CCN_CFG3_MASK       = 8'he0;
    localparam logic [7:0]  CCN_NMI_EXT_MASK    = 8'h07;

    // Reset values
    localparam logic [7:0]  CCN_PERF_RST        = 8'h00;
    localparam logic [7:0]  CCN_CFG3_RST        = 8'h00;
    localparam logic [7:0]  CCN_NMI_EXT_RST     = 8'h07;

    // Always-serialized region, 640 KB up to 1 MB
    localparam logic [31:0] CCN_LEGACY_LO       = 32'h000a_0000;
    localparam logic [31:0] CCN_LEGACY_HI       = 32'h000f_ffff;

    // Top address bits of the three gigabyte regions above 1 GByte
    localparam logic [1:0]  CCN_GB_LOW          = 2'h1;
    localparam logic [1:0]  CCN_GB_MID          = 2'h2;
    localparam logic [1:0]  CCN_GB_HIGH         = 2'h3;

endpackage

// file: logic/ccn_order_sel.sv
// Ordering decision for one memory access, registered
`timescale 1ns/10ps
module ccn_order_sel
    import ccn_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // Ordering controls
    input  wire logic                   load_store_serialize,
    input  wire logic                   region_serialize_high,
    input  wire logic                   region_serialize_mid,
    input  wire logic                   region_serialize_low,
    // Access in
    input  wire logic                   acc_valid,
    input  wire logic [CCN_MADDR_W-1:0] acc_addr,
    // Decision out
    output logic                        dec_valid,
    output logic                        dec_serialize
);

    wire logic [1:0] gb_sel;
    wire logic       in_legacy;
    wire logic       above_gb;
    wire logic       region_ser;
    wire logic       serialize;

    logic            dec_valid_r;
    logic            dec_serialize_r;

    assign gb_sel    = acc_addr[31:30];
    assign above_gb  = (gb_sel != 2'h0);
    assign in_legacy = (acc_addr >= CCN_LEGACY_LO) &&
                       (acc_addr <= CCN_LEGACY_HI);

    // Above 1 GByte the global bit has no say
    assign region_ser =
        ((gb_sel == CCN_GB_LOW)  && region_serialize_low)  ||
        ((gb_sel == CCN_GB_MID)  && region_serialize_mid)  ||
        ((gb_sel == CCN_GB_HIGH) && region_serialize_high);

    assign serialize = in_legacy ? 1'b1 :
                       above_gb  ? region_ser :
                       load_store_serialize;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dec_valid_r     <= 1'b0;
            dec_serialize_r <= 1'b0;
        end else begin
            dec_valid_r     <= acc_valid;
            dec_serialize_r <= acc_valid & serialize;
        end
    end

    assign dec_valid     = dec_valid_r;
    assign dec_serialize = dec_serialize_r;

endmodule

// file: logic/ccn_cfg_regs.sv
// Configuration register bank: NMI trigger, extension enable, ordering
//
// Function
// - Writing one raises NMI; zero does nothing
// - One NMI per fresh zero-to-one setting
// - Extension enable bit admits extended multimedia instructions
// - Serialize bit set forces strict memory order below 1 GByte
// - Serialize bit clear allows memory reordering below 1 GByte, except from 640 KB up to 1 MB
// - Above 1 GByte, per-region fields decide ordering
`timescale 1ns/10ps
module ccn_cfg_regs
    import ccn_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // Register port
    input  wire logic [CCN_ADDR_W-1:0]  reg_addr,
    input  wire logic [CCN_DATA_W-1:0]  reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [CCN_DATA_W-1:0]  reg_rdata,
    // Interrupt to the core
    output logic                        nmi_pulse,
    // Instruction decode gate
    input  wire logic                   insn_ext_valid,
    output logic                        insn_ext_accept,
    output logic                        insn_ext_fault,
    // Level copies of the controls
    output logic                        extended_multimedia_insn_enable,
    output logic                        load_store_serialize,
    // Memory ordering query
    input  wire logic                   acc_valid,
    input  wire logic [CCN_MADDR_W-1:0] acc_addr,
    output logic                        acc_dec_valid,
    output logic                        acc_serialize
);

    // Register storage
    logic [CCN_DATA_W-1:0] perf_ctrl_r;
    logic [CCN_DATA_W-1:0] perf_ctrl_nxt;
    logic [CCN_DATA_W-1:0] cfg_three_r;
    logic [CCN_DATA_W-1:0] cfg_three_nxt;
    logic [CCN_DATA_W-1:0] nmi_ext_r;
    logic [CCN_DATA_W-1:0] nmi_ext_nxt;
    logic [CCN_DATA_W-1:0] rdata_r;
    logic [CCN_DATA_W-1:0] rdata_nxt;
    logic                  nmi_r;
    logic                  nmi_nxt;
    logic                  ext_accept_r;
    logic                  ext_fault_r;

    // Decode
    wire logic             hit_perf;
    wire logic             hit_cfg3;
    wire logic             hit_nmi;
    wire logic             wr_perf;
    wire logic             wr_cfg3;
    wire logic             wr_nmi;
    wire logic             nmi_was_set;
    wire logic             nmi_set_now;
    wire logic             ext_en;
    wire logic [CCN_DATA_W-1:0] rd_sel;

    assign hit_perf = (reg_addr == CCN_IDX_PERF_CTRL);
    assign hit_cfg3 = (reg_addr == CCN_IDX_CFG_THREE);
    assign hit_nmi  = (reg_addr == CCN_IDX_NMI_EXT);

    assign wr_perf  = reg_wr & hit_perf;
    assign wr_cfg3  = reg_wr & hit_cfg3;
    assign wr_nmi   = reg_wr & hit_nmi;

    // Unused bits are dropped at write so they read as zero
    assign perf_ctrl_nxt = wr_perf ? (reg_wdata & CCN_PERF_MASK)
                                   : perf_ctrl_r;
    assign cfg_three_nxt = wr_cfg3 ? (reg_wdata & CCN_CFG3_MASK)
                                   : cfg_three_r;

    // Reserved bit one is stored as written; zero is up to software
    assign nmi_ext_nxt   = wr_nmi ? (reg_wdata & CCN_NMI_EXT_MASK)
                                  : nmi_ext_r;

    // Trigger fires only on a zero-to-one change of the stored bit
    assign nmi_was_set = nmi_ext_r[CCN_NMI_GEN_BIT];
    assign nmi_set_now = reg_wdata[CCN_NMI_GEN_BIT];
    assign nmi_nxt     = wr_nmi & nmi_set_now & ~nmi_was_set;

    // Read mux; unmapped indexes answer zero
    assign rd_sel = hit_perf ? perf_ctrl_r :
                    hit_cfg3 ? cfg_three_r :
                    hit_nmi  ? nmi_ext_r   :
                    8'h00;

    // Read data live for exactly the cycle after the strobe
    assign rdata_nxt = reg_rd ? rd_sel : 8'h00;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            perf_ctrl_r <= CCN_PERF_RST;
            cfg_three_r <= CCN_CFG3_RST;
            nmi_ext_r   <= CCN_NMI_EXT_RST;
        end else begin
            perf_ctrl_r <= perf_ctrl_nxt;
            cfg_three_r <= cfg_three_nxt;
            nmi_ext_r   <= nmi_ext_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_r <= 8'h00;
            nmi_r   <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            nmi_r   <= nmi_nxt;
        end
    end

    // Reset value leaves the trigger bit at one, so no NMI out of reset
    assign nmi_pulse = nmi_r;

    // Extended instruction gate
    assign ext_en = nmi_ext_r[CCN_EXT_EN_BIT];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_accept_r <= 1'b0;
            ext_fault_r  <= 1'b0;
        end else begin
            ext_accept_r <= insn_ext_valid & ext_en;
            ext_fault_r  <= insn_ext_valid & ~ext_en;
        end
    end

    assign insn_ext_accept = ext_accept_r;
    assign insn_ext_fault  = ext_fault_r;

    assign extended_multimedia_insn_enable = ext_en;
    assign load_store_serialize = perf_ctrl_r[CCN_LOAD_STORE_SERIALIZE_BIT];

    assign reg_rdata = rdata_r;

    // Ordering decision; region fields win above 1 GByte
    ccn_order_sel u_order_sel (
        .clk                   (clk),
        .sys_rst               (sys_rst),
        .load_store_serialize  (perf_ctrl_r[CCN_LOAD_STORE_SERIALIZE_BIT]),
        .region_serialize_high (cfg_three_r[CCN_RSER_HIGH_BIT]),
        .region_serialize_mid  (cfg_three_r[CCN_RSER_MID_BIT]),
        .region_serialize_low  (cfg_three_r[CCN_RSER_LOW_BIT]),
        .acc_valid             (acc_valid),
        .acc_addr              (acc_addr),
        .dec_valid             (acc_dec_valid),
        .dec_serialize         (acc_serialize)
    );

endmodule

// file: sim/ccn_cfg_regs_assertions.sv
// Assertions for the configuration register bank
`timescale 1ns/10ps
module ccn_cfg_regs_checker
    import ccn_pkg::*;
(
    // Clock, reset, register port
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // Core side
    input wire logic        nmi_pulse,
    input wire logic        insn_ext_valid,
    input wire logic        insn_ext_accept,
    input wire logic        insn_ext_fault,
    input wire logic        extended_multimedia_insn_enable,
    input wire logic        load_store_serialize,
    input wire logic        acc_valid,
    input wire logic [31:0] acc_addr,
    input wire logic        acc_dec_valid,
    input wire logic        acc_serialize
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Shadows, so a stuck stored bit shows up
    logic       nmi_q;
    logic       en_q;
    logic       lss_q;
    logic [2:0] rs_q;
    wire        set1  = reg_wr && reg_addr == 8'h22 && reg_wdata[2];
    wire        fresh = set1 && !nmi_q;
    wire [1:0]  gb    = acc_addr[31:30];
    wire        low   = acc_addr >= CCN_LEGACY_LO && acc_addr <= CCN_LEGACY_HI;
    wire        lo_q  = acc_valid && gb == 2'h0;
    wire        rsel  = gb == 2'h1 ? rs_q[0] : gb == 2'h2 ? rs_q[1] : rs_q[2];
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            nmi_q <= 1'h1;
            en_q  <= 1'h1;
            lss_q <= 1'h0;
            rs_q  <= 3'h0;
        end else if (reg_wr) begin
            if (reg_addr == 8'h20) lss_q <= reg_wdata[7];
            if (reg_addr == 8'h21) rs_q <= reg_wdata[7:5];
            if (reg_addr == 8'h22) nmi_q <= reg_wdata[2];
            if (reg_addr == 8'h22) en_q <= reg_wdata[0];
        end
    end
    a_nmi_raise: assert property (fresh |=> nmi_pulse)
        else $error("nmi not raised");
    a_nmi_cause: assert property (nmi_pulse |-> $past(fresh))
        else $error("nmi without fresh set");
    a_ext_accept: assert property (
        insn_ext_valid && en_q |=> insn_ext_accept)
        else $error("instruction not accepted");
    a_ext_fault: assert property (
        insn_ext_valid && !en_q |=> insn_ext_fault)
        else $error("instruction not refused");
    a_ext_level: assert property (
        extended_multimedia_insn_enable == en_q)
        else $error("extension enable level wrong");
    a_lss_level: assert property (load_store_serialize == lss_q)
        else $error("serialize level wrong");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    a_ord_strict: assert property (lo_q && lss_q |=> acc_serialize)
        else $error("strict order lost");
    a_ord_free: assert property (
        lo_q && !low && !lss_q |=> !acc_serialize)
        else $error("reorder blocked");
    a_ord_legacy: assert property (
        acc_valid && low |=> acc_dec_valid && acc_serialize)
        else $error("legacy range not serialized");
    a_ord_region: assert property (
        acc_valid && gb != 2'h0 |=> acc_serialize == $past(rsel))
        else $error("region field ignored");
    c_nmi: cover property (nmi_pulse);
    c_fault: cover property (insn_ext_fault);
    c_region: cover property (acc_valid && gb != 2'h0 && rsel);
endmodule
bind ccn_cfg_regs ccn_cfg_regs_checker u_chk (.clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nmi_pulse, .insn_ext_valid,
    .insn_ext_accept, .insn_ext_fault, .extended_multimedia_insn_enable,
    .load_store_serialize, .acc_valid, .acc_addr, .acc_dec_valid,
    .acc_serialize);

// file: sim/test_ccn_cfg_regs.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_ccn_cfg_regs import ccn_pkg::*;;
    logic clk, sys_rst, reg_wr, reg_rd, insn_ext_valid, acc_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, s_rd;
    logic [31:0] acc_addr;
    logic nmi_pulse, insn_ext_accept, insn_ext_fault, acc_dec_valid;
    logic acc_serialize, extended_multimedia_insn_enable, load_store_serialize;
    logic s_nmi, s_acc, s_flt, s_dv, s_ser, s_en, s_lss;
    int miscompares = 0, n_tests = 0, cycles = 0;
    ccn_cfg_regs DUT (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .nmi_pulse, .insn_ext_valid, .insn_ext_accept,
        .insn_ext_fault, .extended_multimedia_insn_enable,
        .load_store_serialize, .acc_valid, .acc_addr, .acc_dec_valid,
        .acc_serialize);
    // One cycle of requests; snapshot shows the previous request's answer
    task automatic cyc(logic w, r, logic [7:0] a, d, logic iv, av,
        logic [31:0] aa);
        {reg_wr, reg_rd, insn_ext_valid, acc_valid} <= {w, r, iv, av};
        {reg_addr, reg_wdata, acc_addr} <= {a, d, aa};
        #1;
        {s_rd, s_nmi, s_acc, s_flt} = {reg_rdata, nmi_pulse,
            insn_ext_accept, insn_ext_fault};
        {s_dv, s_ser, s_en, s_lss} = {acc_dec_valid, acc_serialize,
            extended_multimedia_insn_enable, load_store_serialize};
        @(posedge clk);
    endtask
    task automatic idl();
        cyc(0, 0, 0, 0, 0, 0, 0);
    endtask
    task automatic wr(logic [7:0] a, d);
        cyc(1, 0, a, d, 0, 0, 0);
    endtask
    task automatic nmi(logic e);
        idl();
        `CHK(s_nmi, e)
    endtask
    task automatic rc(logic [7:0] a, e);
        cyc(0, 1, a, 0, 0, 0, 0);
        idl();
        `CHK(s_rd, e)
    endtask
    task automatic q(logic [31:0] aa, logic e);
        cyc(0, 0, 0, 0, 0, 1, aa);
        idl();
        `CHK(s_dv, 1'h1)
        `CHK(s_ser, e)
    endtask
    task automatic ins(logic e);
        cyc(0, 0, 0, 0, 1, 0, 0);
        idl();
        `CHK(s_acc, e)
        `CHK(s_flt, !e)
    endtask
    task print_verdict;
        if (miscompares == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    // Whole run is about 80 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        sys_rst = 1;
        {reg_wr, reg_rd, insn_ext_valid, acc_valid} = 4'h0;
        {reg_addr, reg_wdata, acc_addr} = 48'h0;
        repeat (16) @(posedge clk);
        sys_rst <= 0;
        idl();
        `CHK(s_en, 1'h1)
        `CHK(s_lss, 1'h0)
        rc(8'h20, 8'h00);
        rc(8'h21, 8'h00);
        rc(8'h22, 8'h07);
        wr(8'h22, 8'h05);
        nmi(0);
        wr(8'h22, 8'h01);
        wr(8'h22, 8'h05);
        nmi(1);
        wr(8'h22, 8'h05);
        nmi(0);
        wr(8'h22, 8'h00);
        nmi(0);
        ins(0);
        `CHK(s_en, 1'h0)
        wr(8'h22, 8'hfd);
        nmi(1);
        ins(1);
        `CHK(s_en, 1'h1)
        rc(8'h22, 8'h05);
        q(32'h0010_0000, 0);
        q(32'h0009_ffff, 0);
        q(32'h000a_0000, 1);
        q(32'h000f_ffff, 1);
        wr(8'h20, 8'h80);
        q(32'h0010_0000, 1);
        `CHK(s_lss, 1'h1)
        // Serialize bit set must not leak into the upper regions
        wr(8'h21, 8'ha0);
        q(32'h4000_0000, 1);
        q(32'h8000_0000, 0);
        q(32'hc000_0000, 1);
        wr(8'h20, 8'h00);
        wr(8'h21, 8'h40);
        q(32'h7fff_ffff, 0);
        q(32'hbfff_ffff, 1);
        q(32'hffff_ffff, 0);
        wr(8'h3c, 8'hff);
        rc(8'h3c, 8'h00);
        rc(8'h21, 8'h40);
        rc(8'h20, 8'h00);
        // Mid-run reset must bring back the reset values
        sys_rst <= 1;
        idl();
        sys_rst <= 0;
        idl();
        rc(8'h22, 8'h07);
        rc(8'h21, 8'h00);
        print_verdict();
    end
endmodule
